// File: core/cidc_core.sv
// Purpose: caller-id detect control, flags and guard timing
// Assumes: line-side detector outputs are asynchronous levels
// Notes:   registers over classic wishbone, one cycle ack
//
// Notes on behaviour
// - global enable low stops fsk, alert and dtmf functions together.
// - each of fsk, alert, dtmf has its own enable under global.
// - ring detection always runs, whatever the enables say.
// - ring envelope rising edge sets ring flag, bit 0 of flags.
// - recognised alert raises alert status; its rise sets alert flag.
// - guard timer ticks every 0.858 ms.
// - raw tone rise resets guard timer, counts up from zero.
// - timer equal to present time stops it and sets status.
// - raw tone fall restarts timer; absent time match clears status.
// - alert status is changed by hardware only.
// - alert flag set on status rise, held until software clears.
// - dtmf presence and absence use same guard method, own times.
// - recognised digit sets dtmf valid and stores 4-bit code.
// - decoder mode distinguishes all 16 digit codes.
// - dtmf valid hardware only; rise sets sticky dtmf flag.
// - config two bit 4 selects tone-detector mode.
// - tone mode shows high and low group presence immediately.
// - fsk data demodulated at 1200 baud into bytes.
// - each fsk byte pulses ready, loads byte; sets sticky flag.
// - carrier detect after 8 ms energy, released after 8 ms absence.
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cidc_map.svh"

module cidc_core #(
    parameter int TICK_CYCLES = `CIDC_TICK_NS / `CIDC_CLK_NS,
    parameter int CARRIER_CYCLES = (`CIDC_CARRIER_NS + `CIDC_CLK_NS - 1) / `CIDC_CLK_NS,
    parameter int BAUD_CYCLES = `CIDC_NS_PER_S / (`CIDC_FSK_BAUD * `CIDC_CLK_NS)
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // line-side detectors, asynchronous
    input wire logic ring_envelope_i,
    input wire logic raw_tone_detect_i,
    input wire logic dtmf_tone_detect_i,
    input wire logic [3:0] dtmf_code_i,
    input wire logic low_group_i,
    input wire logic high_group_i,
    input wire logic fsk_energy_i,
    input wire logic fsk_serial_i,
    // front-end enables and interrupt
    output logic fsk_run_o,
    output logic alert_run_o,
    output logic dtmf_run_o,
    output logic callerid_combined_flag_o
);

    localparam int CW = `CIDC_CNT_W;
    localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);
    localparam logic [CW-1:0] CARR_LAST = CW'(CARRIER_CYCLES - 1);
    localparam logic [CW-1:0] BAUD_LAST = CW'(BAUD_CYCLES - 1);
    localparam logic [CW-1:0] HALF_LAST = CW'(BAUD_CYCLES / 2 - 1);

    cidc_pkg::cidc_state_s q;
    cidc_pkg::cidc_state_s n;

    // ------------------------------------------------------------
    // guard-time qualifier, shared by alert and dtmf paths
    // ------------------------------------------------------------
    function automatic cidc_pkg::cidc_guard_s guard_step(
        input cidc_pkg::cidc_guard_s g,
        input logic en,
        input logic raw,
        input logic raw_prev,
        input logic tick,
        input logic [7:0] pt,
        input logic [7:0] at
    );
        cidc_pkg::cidc_guard_s r;
        r = g;
        if (!en) begin
            r = '0;
        end else if (raw != raw_prev) begin
            r.tmr = '0;
            r.run = 1'b1;
        end else if (g.run) begin
            if (raw == g.st) begin
                // tone returned to the qualified state, stop the timer
                r.run = 1'b0;
            end else if (raw && g.tmr == pt) begin
                r.run = 1'b0;
                r.st = 1'b1;
            end else if (!raw && g.tmr == at) begin
                r.run = 1'b0;
                r.st = 1'b0;
            end else if (tick) begin
                r.tmr = g.tmr + 1'b1;
            end
        end
        return r;
    endfunction : guard_step

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic req;
        logic wr;
        logic tick;
        logic en_a;
        logic en_d;
        logic en_f;
        logic tone_mode;
        logic [3:0] clr;
        logic [3:0] set;
        n = q;
        req = wb_cyc_i & wb_stb_i & ~q.ack;
        wr = req & wb_we_i & wb_sel_i[0];
        tick = 1'b0;
        en_a = 1'b0;
        en_d = 1'b0;
        en_f = 1'b0;
        tone_mode = 1'b0;
        clr = '0;
        set = '0;
        n.ack = req;
        n.frdy = 1'b0;

        // line inputs: two flops, then a third for edges
        n.s1 = {dtmf_code_i, fsk_serial_i, fsk_energy_i, high_group_i, low_group_i,
                dtmf_tone_detect_i, raw_tone_detect_i, ring_envelope_i};
        n.s2 = q.s1;
        n.s3 = q.s2;

        // register writes; flags are write-one-to-clear
        if (wr) begin
            case (wb_adr_i)
                `CIDC_ADR_CTRL: n.ctrl = wb_dat_i[3:0];
                `CIDC_ADR_FLAG: clr = wb_dat_i[3:0];
                `CIDC_ADR_APT: n.apt = wb_dat_i[7:0];
                `CIDC_ADR_AAT: n.aat = wb_dat_i[7:0];
                `CIDC_ADR_DPT: n.dpt = wb_dat_i[7:0];
                `CIDC_ADR_DAT: n.dat = wb_dat_i[7:0];
                `CIDC_ADR_CFG2: n.cfg2 = wb_dat_i[7:0];
                default: n.ctrl = q.ctrl;
            endcase
        end

        en_f = q.ctrl[`CIDC_CTRL_GLOB] & q.ctrl[`CIDC_CTRL_FSK];
        en_a = q.ctrl[`CIDC_CTRL_GLOB] & q.ctrl[`CIDC_CTRL_CAS];
        tone_mode = q.cfg2[`CIDC_CFG2_TONE];
        en_d = q.ctrl[`CIDC_CTRL_GLOB] & q.ctrl[`CIDC_CTRL_DTMF];
        n.fsk_run = n.ctrl[`CIDC_CTRL_GLOB] & n.ctrl[`CIDC_CTRL_FSK];
        n.alert_run = n.ctrl[`CIDC_CTRL_GLOB] & n.ctrl[`CIDC_CTRL_CAS];
        n.dtmf_run = n.ctrl[`CIDC_CTRL_GLOB] & n.ctrl[`CIDC_CTRL_DTMF];

        if (q.tick_cnt == TICK_LAST) begin
            n.tick_cnt = '0;
            tick = 1'b1;
        end else begin
            n.tick_cnt = q.tick_cnt + 1'b1;
        end

        set[`CIDC_FLG_RING] = q.s2[`CIDC_S_RING] & ~q.s3[`CIDC_S_RING];

        n.ag = guard_step(q.ag, en_a, q.s2[`CIDC_S_ARAW], q.s3[`CIDC_S_ARAW], tick, q.apt, q.aat);
        set[`CIDC_FLG_ALERT] = n.ag.st & ~q.ag.st;

        n.dg = guard_step(q.dg, en_d & ~tone_mode, q.s2[`CIDC_S_DRAW], q.s3[`CIDC_S_DRAW],
                          tick, q.dpt, q.dat);
        set[`CIDC_FLG_DTMF] = n.dg.st & ~q.dg.st;
        if (n.dg.st & ~q.dg.st) begin
            n.code = q.s2[`CIDC_S_CODE +: 4];
        end
        // tone mode group bits, no guard on purpose
        n.grp_lo = en_d & tone_mode & q.s2[`CIDC_S_LO];
        n.grp_hi = en_d & tone_mode & q.s2[`CIDC_S_HI];

        if (!en_f) begin
            n.fcd = 1'b0;
            n.ccnt = '0;
        end else if (q.s2[`CIDC_S_FEN] == q.fcd) begin
            n.ccnt = '0;
        end else if (q.ccnt == CARR_LAST) begin
            n.fcd = ~q.fcd;
            n.ccnt = '0;
        end else begin
            n.ccnt = q.ccnt + 1'b1;
        end

        // byte framing at baud rate, lsb first
        case (q.fst)
            cidc_pkg::FSK_IDLE: begin
                n.bcnt = '0;
                if (!q.s2[`CIDC_S_FDAT]) begin
                    n.fst = cidc_pkg::FSK_START;
                end
            end
            cidc_pkg::FSK_START: begin
                if (q.bcnt == HALF_LAST) begin
                    // a short low is noise, not a start bit
                    n.fst = q.s2[`CIDC_S_FDAT] ? cidc_pkg::FSK_IDLE : cidc_pkg::FSK_DATA;
                    n.bcnt = '0;
                    n.bitn = '0;
                end else begin
                    n.bcnt = q.bcnt + 1'b1;
                end
            end
            cidc_pkg::FSK_DATA: begin
                if (q.bcnt == BAUD_LAST) begin
                    n.bcnt = '0;
                    n.shreg = {q.s2[`CIDC_S_FDAT], q.shreg[7:1]};
                    n.bitn = q.bitn + 1'b1;
                    if (q.bitn == `CIDC_FSK_LAST_BIT) begin
                        n.fst = cidc_pkg::FSK_STOP;
                    end
                end else begin
                    n.bcnt = q.bcnt + 1'b1;
                end
            end
            cidc_pkg::FSK_STOP: begin
                if (q.bcnt == BAUD_LAST) begin
                    n.fst = cidc_pkg::FSK_IDLE;
                    n.bcnt = '0;
                    if (q.s2[`CIDC_S_FDAT]) begin
                        n.fbyte = q.shreg;
                        n.frdy = 1'b1;
                    end
                end else begin
                    n.bcnt = q.bcnt + 1'b1;
                end
            end
            default: n.fst = cidc_pkg::FSK_IDLE;
        endcase
        if (!en_f) begin
            n.fst = cidc_pkg::FSK_IDLE;
        end
        set[`CIDC_FLG_FSK] = n.frdy;

        n.flags = (q.flags & ~clr) | set;
        n.irq = |n.flags;

        // read data, captured with the ack
        n.rdat = '0;
        if (req & ~wb_we_i) begin
            case (wb_adr_i)
                `CIDC_ADR_CTRL: n.rdat[3:0] = q.ctrl;
                `CIDC_ADR_FLAG: begin
                    n.rdat[3:0] = q.flags;
                    n.rdat[`CIDC_FLG_COMB] = q.irq;
                end
                `CIDC_ADR_STAT: n.rdat[4:0] = {q.s2[`CIDC_S_RING], q.frdy, q.fcd, q.dg.st, q.ag.st};
                `CIDC_ADR_APT: n.rdat[7:0] = q.apt;
                `CIDC_ADR_AAT: n.rdat[7:0] = q.aat;
                `CIDC_ADR_DPT: n.rdat[7:0] = q.dpt;
                `CIDC_ADR_DAT: n.rdat[7:0] = q.dat;
                `CIDC_ADR_CFG2: n.rdat[7:0] = q.cfg2;
                `CIDC_ADR_DDATA: begin
                    n.rdat[3:0] = q.code;
                    n.rdat[`CIDC_DD_LOW] = q.grp_lo;
                    n.rdat[`CIDC_DD_HIGH] = q.grp_hi;
                end
                `CIDC_ADR_FBYTE: n.rdat[7:0] = q.fbyte;
                default: n.rdat = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register, synchronous reset to all zero
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // outputs straight from flops
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign fsk_run_o = q.fsk_run;
    assign alert_run_o = q.alert_run;
    assign dtmf_run_o = q.dtmf_run;
    assign callerid_combined_flag_o = q.irq;

endmodule : cidc_core
`default_nettype wire

// File: core/cidc_map.svh
// Purpose: constants of the caller-id detect control block
// Assumes: 10 MHz system clock, 32-bit classic wishbone
// Notes:   offsets are byte addresses, one aligned word each
`ifndef CIDC_MAP_SVH
`define CIDC_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CIDC_ADR_CTRL 8'h00
`define CIDC_ADR_FLAG 8'h04
`define CIDC_ADR_STAT 8'h08
`define CIDC_ADR_APT 8'h0C
`define CIDC_ADR_AAT 8'h10
`define CIDC_ADR_DPT 8'h14
`define CIDC_ADR_DAT 8'h18
`define CIDC_ADR_CFG2 8'h1C
`define CIDC_ADR_DDATA 8'h20
`define CIDC_ADR_FBYTE 8'h24

// ----------------------------------------
// field positions
// ----------------------------------------
`define CIDC_CTRL_GLOB 0
`define CIDC_CTRL_FSK 1
`define CIDC_CTRL_CAS 2
`define CIDC_CTRL_DTMF 3
`define CIDC_FLG_RING 0
`define CIDC_FLG_ALERT 1
`define CIDC_FLG_DTMF 2
`define CIDC_FLG_FSK 3
`define CIDC_FLG_COMB 7
`define CIDC_CFG2_TONE 4
`define CIDC_DD_LOW 4
`define CIDC_DD_HIGH 5

// ----------------------------------------
// synchroniser vector positions
// ----------------------------------------
`define CIDC_S_RING 0
`define CIDC_S_ARAW 1
`define CIDC_S_DRAW 2
`define CIDC_S_LO 3
`define CIDC_S_HI 4
`define CIDC_S_FEN 5
`define CIDC_S_FDAT 6
`define CIDC_S_CODE 7
`define CIDC_SYNC_W 11

// ----------------------------------------
// timing
// ----------------------------------------
`define CIDC_CLK_NS 100
`define CIDC_TICK_NS 858000
`define CIDC_CARRIER_NS 8000000
`define CIDC_FSK_BAUD 1200
`define CIDC_NS_PER_S 1000000000
`define CIDC_CNT_W 17
`define CIDC_FSK_LAST_BIT 3'h7

`endif

// File: core/cidc_pkg.sv
// Purpose: types of the caller-id detect control block
// Assumes: widths from cidc_map.svh
// Notes:   all state of the core is one packed struct
`include "cidc_map.svh"

package cidc_pkg;

    // fsk byte receiver states
    typedef enum logic [1:0] {
        FSK_IDLE,
        FSK_START,
        FSK_DATA,
        FSK_STOP
    } cidc_fsk_e;

    // one tone guard qualifier
    typedef struct packed {
        logic [7:0] tmr;
        logic run;
        logic st;
    } cidc_guard_s;

    // whole core state
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic irq;
        logic [3:0] ctrl;
        logic [7:0] cfg2;
        logic [7:0] apt;
        logic [7:0] aat;
        logic [7:0] dpt;
        logic [7:0] dat;
        logic [3:0] flags;
        logic [`CIDC_SYNC_W-1:0] s1;
        logic [`CIDC_SYNC_W-1:0] s2;
        logic [`CIDC_SYNC_W-1:0] s3;
        logic [`CIDC_CNT_W-1:0] tick_cnt;
        cidc_guard_s ag;
        cidc_guard_s dg;
        logic [3:0] code;
        logic grp_lo;
        logic grp_hi;
        cidc_fsk_e fst;
        logic [`CIDC_CNT_W-1:0] bcnt;
        logic [2:0] bitn;
        logic [7:0] shreg;
        logic [7:0] fbyte;
        logic frdy;
        logic fcd;
        logic [`CIDC_CNT_W-1:0] ccnt;
        logic fsk_run;
        logic alert_run;
        logic dtmf_run;
    } cidc_state_s;

endpackage : cidc_pkg

// File: testbench/cidc_core_sva.sv
// Purpose: port checks of the caller-id detect control core
// Assumes: one clock, synchronous active-high reset
// Notes:   helper state tracks control writes and flag clears
`timescale 1ns/1ps
`default_nettype none
`include "cidc_map.svh"

module cidc_core_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // line side and outputs
    input wire logic ring_envelope_i,
    input wire logic fsk_run_o,
    input wire logic alert_run_o,
    input wire logic dtmf_run_o,
    input wire logic callerid_combined_flag_o
);
    // ------
    // helper state
    // ------
    typedef struct packed {
        logic [3:0] ctrl;
        logic [1:0] quiet;
        logic [1:0] since;
    } cidc_chk_s;
    cidc_chk_s chk_ff;
    cidc_chk_s nxt_chk;
    logic wr;

    // a write only counts with lane 0 set
    assign wr = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];

    // saturating ages let outputs settle before they are judged
    always_comb begin
        nxt_chk = chk_ff;
        if (chk_ff.quiet != 2'h3) nxt_chk.quiet = chk_ff.quiet + 2'h1;
        if (chk_ff.since != 2'h3) nxt_chk.since = chk_ff.since + 2'h1;
        if (wr && wb_adr_i == `CIDC_ADR_CTRL) begin
            nxt_chk.ctrl = wb_dat_i[3:0];
            nxt_chk.quiet = 2'h0;
        end
        if (wr && wb_adr_i == `CIDC_ADR_FLAG) nxt_chk.since = 2'h0;
    end

    // register helper state
    always_ff @(posedge clk_i) begin
        chk_ff <= rst_i ? '0 : nxt_chk;
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_global_off: assert property (chk_ff.quiet >= 2'h2 && !chk_ff.ctrl[0] |-> !fsk_run_o && !alert_run_o && !dtmf_run_o)
        else $error("run enable high while global enable low");
    a_own_enable: assert property (chk_ff.quiet >= 2'h2 && chk_ff.ctrl[0] |->
        fsk_run_o == chk_ff.ctrl[1] && alert_run_o == chk_ff.ctrl[2] && dtmf_run_o == chk_ff.ctrl[3])
        else $error("run enable differs from own enable");
    a_ring_flag: assert property ($rose(ring_envelope_i) |-> ##[1:6] callerid_combined_flag_o)
        else $error("ring rise did not raise combined flag");
    a_comb_sticky: assert property ($fell(callerid_combined_flag_o) |-> chk_ff.since <= 2'h1)
        else $error("combined flag fell without a clear");
    a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) // bus handshake
        else $error("ack not a one cycle answer");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i) && !$past(wb_ack_o)) // bus handshake
        else $error("ack without request");
    a_rdat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) // bus read data
        else $error("read data outside ack");
    a_rdat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000) // bus read data
        else $error("upper read bits not zero");

    // main scenarios reached
    c_flag_set: cover property ($rose(callerid_combined_flag_o));
    c_flag_clr: cover property ($fell(callerid_combined_flag_o));
    c_all_run: cover property (fsk_run_o && alert_run_o && dtmf_run_o);
endmodule : cidc_core_sva

bind cidc_core cidc_core_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ring_envelope_i(ring_envelope_i), .fsk_run_o(fsk_run_o), .alert_run_o(alert_run_o),
    .dtmf_run_o(dtmf_run_o), .callerid_combined_flag_o(callerid_combined_flag_o));
`default_nettype wire

// File: testbench/cidc_line_model.sv
// Purpose: line front end and tone filters facing the core
// Assumes: detector levels change only on a clock edge
// Notes:   serial line idles high between frames
`timescale 1ns/1ps
`default_nettype none

module cidc_line_model #(
    parameter int BAUD = 16
) (
    // clock
    input wire logic clk_i,
    // detector levels: ring, alert, dtmf, code, low, high, energy
    output logic [9:0] lvl_o,
    // fsk serial data
    output logic ser_o
);
    // ------
    // levels and frames
    // ------
    // quiet line at time zero
    initial begin
        lvl_o = 10'h000;
        ser_o = 1'b1;
    end

    // detector levels move together after an edge
    task automatic drive(input logic [9:0] v);
        @(posedge clk_i);
        lvl_o <= v;
    endtask : drive

    // start, eight bits lsb first, stop
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            ser_o <= f[i];
            repeat (BAUD - 1) @(posedge clk_i);
        end
    endtask : send
endmodule : cidc_line_model
`default_nettype wire

// File: testbench/tb_caller_id_detect_control.sv
// Purpose: self-checking bench of the caller-id detect control core
// Assumes: shortened tick, carrier and baud counts
// Notes:   random control words and bytes from a fixed lfsr
`timescale 1ns/1ps
`default_nettype none
`include "cidc_map.svh"

module tb_caller_id_detect_control;
    localparam int T = 4;
    localparam int B = 16;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [3:0] sel = 4'hf;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [31:0] rdat, q;
    logic [31:0] seed = 32'h0373_0cac;
    logic ack, fsk_run, alert_run, dtmf_run, comb, ser;
    logic [9:0] lvl;
    logic [9:0] want = 10'h000;
    logic [3:0] c;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    int n;

    // ------
    // clock, design and line
    // ------
    always #50 clk_i = ~clk_i;

    cidc_core #(.TICK_CYCLES(T), .CARRIER_CYCLES(20), .BAUD_CYCLES(B)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ring_envelope_i(lvl[9]), .raw_tone_detect_i(lvl[8]),
        .dtmf_tone_detect_i(lvl[7]), .dtmf_code_i(lvl[6:3]), .low_group_i(lvl[2]), .high_group_i(lvl[1]),
        .fsk_energy_i(lvl[0]), .fsk_serial_i(ser), .fsk_run_o(fsk_run), .alert_run_o(alert_run),
        .dtmf_run_o(dtmf_run), .callerid_combined_flag_o(comb));

    cidc_line_model #(.BAUD(B)) line (.clk_i(clk_i), .lvl_o(lvl), .ser_o(ser));

    // expected enables in {dtmf, alert, fsk} order
    function automatic logic [2:0] exp_run(input logic [3:0] v);
        return v[3:1] & {3{v[0]}};
    endfunction : exp_run

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t level %b expected %b", $time, got, exp);
        end
    endtask : chk_pin

    task automatic finish_test;
        if (fails == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test

    // classic cycle; the answer is awaited, never assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h00_0000, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 40);
        if (k >= 40) fails++;
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk_reg(q, {24'h00_0000, e});
    endtask : rd

    task automatic put;
        line.drive(want);
    endtask : put

    // a hang counts as a mismatch
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 10000) begin
            fails++;
            finish_test();
        end
    end

    // ------
    // scenarios
    // ------
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`CIDC_ADR_CTRL, 8'h00);
        wb(1'b1, 8'h3c, 8'hff);
        rd(8'h3c, 8'h00);
        wb(1'b1, `CIDC_ADR_CTRL, 8'hff);
        rd(`CIDC_ADR_CTRL, 8'h0f);
        sel <= 4'he;
        wb(1'b1, `CIDC_ADR_CTRL, 8'h00);
        sel <= 4'hf;
        rd(`CIDC_ADR_CTRL, 8'h0f);
        // random enables, then global off with all own bits on, then global on with all own bits off
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            c = (i < 10) ? seed[3:0] : ((i == 10) ? 4'he : 4'h1);
            wb(1'b1, `CIDC_ADR_CTRL, {4'h0, c});
            repeat (3) @(posedge clk_i);
            chk_reg({29'h0, dtmf_run, alert_run, fsk_run}, {29'h0, exp_run(c)});
        end
        // ring works with every enable off
        wb(1'b1, `CIDC_ADR_CTRL, 8'h00);
        want[9] = 1'b1;
        put();
        repeat (8) @(posedge clk_i);
        chk_pin(comb, 1'b1);
        rd(`CIDC_ADR_FLAG, 8'h81);
        wb(1'b1, `CIDC_ADR_FLAG, 8'h01);
        rd(`CIDC_ADR_FLAG, 8'h00);
        chk_pin(comb, 1'b0);
        want[9] = 1'b0;
        put();
        // alert tone: qualifying, own enable off, global off
        wb(1'b1, `CIDC_ADR_APT, 8'h03);
        wb(1'b1, `CIDC_ADR_AAT, 8'h02);
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, `CIDC_ADR_CTRL, (i == 0) ? 8'h05 : ((i == 1) ? 8'h01 : 8'h0e));
            want[8] = 1'b1;
            put();
            n = 0;
            while (comb !== 1'b1 && n < 60) begin
                @(posedge clk_i);
                n++;
            end
            if (i == 0) begin
                chk_pin(n >= 2 * T && n <= 4 * T + 6, 1'b1);
                rd(`CIDC_ADR_STAT, 8'h01);
                wb(1'b1, `CIDC_ADR_STAT, 8'h00);
                rd(`CIDC_ADR_STAT, 8'h01);
            end
            rd(`CIDC_ADR_FLAG, (i == 0) ? 8'h82 : 8'h00);
            want[8] = 1'b0;
            put();
            rd(`CIDC_ADR_STAT, (i == 0) ? 8'h01 : 8'h00);
            repeat (4 * T + 8) @(posedge clk_i);
            rd(`CIDC_ADR_STAT, 8'h00);
            rd(`CIDC_ADR_FLAG, (i == 0) ? 8'h82 : 8'h00);
            wb(1'b1, `CIDC_ADR_FLAG, 8'h0f);
        end
        // every digit code through the dtmf guard
        wb(1'b1, `CIDC_ADR_DPT, 8'h01);
        wb(1'b1, `CIDC_ADR_DAT, 8'h01);
        wb(1'b1, `CIDC_ADR_CTRL, 8'h09);
        for (int k = 0; k < 16; k++) begin
            want[7:3] = {1'b1, k[3:0]};
            put();
            repeat (3 * T + 8) @(posedge clk_i);
            rd(`CIDC_ADR_DDATA, {4'h0, k[3:0]});
            rd(`CIDC_ADR_FLAG, 8'h84);
            want[7] = 1'b0;
            put();
            repeat (3 * T + 8) @(posedge clk_i);
            rd(`CIDC_ADR_STAT, 8'h00);
            wb(1'b1, `CIDC_ADR_FLAG, 8'h04);
        end
        // tone-detector mode shows group presence
        wb(1'b1, `CIDC_ADR_CFG2, 8'h10);
        for (int k = 1; k < 4; k++) begin
            want[2:1] = k[1:0];
            put();
            repeat (5) @(posedge clk_i);
            wb(1'b0, `CIDC_ADR_DDATA, 8'h00);
            chk_reg(q & 32'h0000_0030, {26'h000_0000, k[0], k[1], 4'h0});
        end
        want[2:1] = 2'b00;
        put();
        // carrier hysteresis and random bytes
        wb(1'b1, `CIDC_ADR_CTRL, 8'h03);
        want[0] = 1'b1;
        put();
        repeat (8) @(posedge clk_i);
        rd(`CIDC_ADR_STAT, 8'h00);
        repeat (20) @(posedge clk_i);
        rd(`CIDC_ADR_STAT, 8'h04);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            line.send(seed[7:0]);
            repeat (6) @(posedge clk_i);
            rd(`CIDC_ADR_FBYTE, seed[7:0]);
            rd(`CIDC_ADR_FLAG, 8'h88);
            wb(1'b1, `CIDC_ADR_FLAG, 8'h08);
        end
        want[0] = 1'b0;
        put();
        repeat (30) @(posedge clk_i);
        rd(`CIDC_ADR_STAT, 8'h00);
        finish_test();
    end
endmodule : tb_caller_id_detect_control
`default_nettype wire
